/* rtl/multi_channel_pwm_timer.sv */
// Operation
// - Counter clock passes a 16-bit prescaler; counter auto-reloads.
// - Wide counter of 32 bits counts up, down or up/down.
// - Four channels: capture, compare, PWM or one-pulse each.
// - PWM is edge-aligned or center-aligned by configuration.
// - Three complementary outputs with programmable dead time.
// - PWM duty covers fully inactive to fully active.
// - Counter stops during debug halt when freeze is enabled.
// - Trigger in/out lets timers start, gate or clock each other.
// - Quadrature encoder inputs step the counter up or down.
// - Up to three hall sensor inputs feed channel capture.
// - Each timer raises its own DMA requests.
// - Light variants count up only outside encoder mode, with one or two channels.
// - Single/dual-channel variants have one complementary output.
// - Basic variant: time base whose update triggers the DAC.
`timescale 1ns/1ps
`default_nettype none

module multi_channel_pwm_timer
  import pwm_timer_pkg::*;
#(
  parameter int CNT_W    = 32,
  parameter int NUM_CH   = 4,
  parameter int NUM_COMP = 3,
  parameter bit UP_ONLY  = 1'b0
) (
  // Clock and reset
  input  wire logic                ref_clk,
  input  wire logic                arst_n,
  // AHB-Lite slave
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic      [31:0]         hrdata,
  output logic                     hreadyout,
  output logic                     hresp,
  // Channel pins
  input  wire logic [NUM_CH-1:0]   capPin,
  output logic      [NUM_CH-1:0]   chOut,
  output logic      [NUM_COMP-1:0] chOutN,
  // Timer link and debug
  input  wire logic                trigIn,
  output logic                     trigOut,
  input  wire logic                dbgHalt,
  // Interrupt and DMA
  output logic                     irq,
  output logic      [NUM_CH:0]     dmaReq
);

  localparam int ST_W = NUM_CH + 2;

  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  logic [CTRL_W-1:0]         ctrl_r;
  logic [PSC_W-1:0]          psc_r;
  logic [PSC_W-1:0]          pscCnt_r;
  logic [CNT_W-1:0]          arr_r;
  logic [CNT_W-1:0]          cnt_r;
  logic                      dirDown_r;
  logic [ST_W-1:0]           status_r;
  logic [ST_W-1:0]           mask_r;
  logic [ST_W-1:0]           dmaEn_r;
  logic [DT_W-1:0]           deadTime_r;
  logic [CHCFG_W*NUM_CH-1:0] chCfg_r;
  logic [NUM_CH-1:0]         pinMeta_r;
  logic [NUM_CH-1:0]         pinSync_r;
  logic                      trigPrev_r;
  logic [1:0]                encPrev_r;
  logic                      wrPend_r;
  logic [7:0]                wrAddr_r;
  logic [31:0]               rdVal;
  logic [CNT_W-1:0]          ccr   [NUM_CH];
  logic [NUM_CH-1:0]         chRef;
  logic [NUM_CH-1:0]         chEvt;
  logic [NUM_CH-1:0]         capIn;

  slaveMode_t slaveMode;
  logic       addrPhase;
  logic       rdStatus;
  logic       trigRise;
  logic       encStep;
  logic       encUp;
  logic       freeze;
  logic       run;
  logic       pscHit;
  logic       tick;
  logic       center;
  logic       down;
  logic       atEnd;
  logic       updEvt;
  logic       trigStart;
  logic [ST_W-1:0] setVec;

  // ----------------------------------------------------------------
  // Bus slave: zero wait states, always OKAY
  // ----------------------------------------------------------------
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign addrPhase = hsel && htrans[1] && hready;
  assign rdStatus  = addrPhase && !hwrite && haddr[7:0] == OFF_STATUS;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wrPend_r <= 1'b0;
      wrAddr_r <= 8'h00;
    end else if (hready) begin
      wrPend_r <= addrPhase && hwrite && hsize == 3'h2;
      wrAddr_r <= haddr[7:0];
    end
  end

  always_comb begin
    rdVal = 32'h0000_0000;
    unique case (haddr[7:0])
      OFF_CTRL:   rdVal[CTRL_W-1:0]          = ctrl_r;
      OFF_PSC:    rdVal[PSC_W-1:0]           = psc_r;
      OFF_ARR:    rdVal[CNT_W-1:0]           = arr_r;
      OFF_CNT:    rdVal[CNT_W-1:0]           = cnt_r;
      OFF_STATUS: rdVal[ST_W-1:0]            = status_r;
      OFF_MASK:   rdVal[ST_W-1:0]            = mask_r;
      OFF_DMAEN:  rdVal[ST_W-1:0]            = dmaEn_r;
      OFF_DEAD:   rdVal[DT_W-1:0]            = deadTime_r;
      OFF_CHCFG:  rdVal[CHCFG_W*NUM_CH-1:0]  = chCfg_r;
      default: begin
        for (int i = 0; i < NUM_CH; i++) begin
          if (haddr[7:0] == 8'(OFF_CCR0 + 4 * i)) begin
            rdVal[CNT_W-1:0] = ccr[i];
          end
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      hrdata <= 32'h0000_0000;
    end else if (addrPhase && !hwrite) begin
      hrdata <= rdVal;
    end
  end

  // ----------------------------------------------------------------
  // Plain configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      psc_r      <= PSC_RST;
      arr_r      <= '1;
      mask_r     <= '0;
      dmaEn_r    <= '0;
      deadTime_r <= DT_RST;
      chCfg_r    <= '0;
    end else if (wrPend_r) begin
      unique case (wrAddr_r)
        OFF_PSC:   psc_r      <= hwdata[PSC_W-1:0];
        OFF_ARR:   arr_r      <= hwdata[CNT_W-1:0];
        OFF_MASK:  mask_r     <= hwdata[ST_W-1:0];
        OFF_DMAEN: dmaEn_r    <= hwdata[ST_W-1:0];
        OFF_DEAD:  deadTime_r <= hwdata[DT_W-1:0];
        OFF_CHCFG: chCfg_r    <= hwdata[CHCFG_W*NUM_CH-1:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers and hall combination
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pinMeta_r <= '0;
      pinSync_r <= '0;
    end else begin
      pinMeta_r <= capPin;
      pinSync_r <= pinMeta_r;
    end
  end

  always_comb begin
    capIn = pinSync_r;
    if (ctrl_r[CTRL_HALL] && NUM_CH >= 3) begin
      capIn[0] = ^pinSync_r[2:0];
    end
  end

  // ----------------------------------------------------------------
  // Clock selection, prescaler and slave modes
  // ----------------------------------------------------------------
  assign slaveMode = slaveMode_t'(ctrl_r[CTRL_SMS+:3]);
  assign trigRise  = trigIn && !trigPrev_r;
  assign trigStart = trigRise && slaveMode == SM_TRIG_START;
  assign encStep   = |(encPrev_r ^ pinSync_r[1:0]);
  assign encUp     = pinSync_r[0] ^ encPrev_r[1];
  assign freeze    = dbgHalt && ctrl_r[CTRL_FRZ];
  assign run       = ctrl_r[CTRL_EN] && !freeze
                     && (slaveMode != SM_GATED || trigIn);

  always_comb begin
    unique case (slaveMode)
      SM_EXT_CLOCK: pscHit = run && trigRise;
      SM_ENCODER:   pscHit = run && encStep;
      default:      pscHit = run;
    endcase
  end

  assign tick = pscHit && (slaveMode == SM_ENCODER || pscCnt_r == psc_r);

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      trigPrev_r <= 1'b0;
      encPrev_r  <= 2'b00;
    end else begin
      trigPrev_r <= trigIn;
      encPrev_r  <= pinSync_r[1:0];
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pscCnt_r <= '0;
    end else if (trigStart || (wrPend_r && wrAddr_r == OFF_CNT)) begin
      pscCnt_r <= '0;
    end else if (pscHit) begin
      pscCnt_r <= (pscCnt_r == psc_r) ? '0 : pscCnt_r + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Counter core
  // ----------------------------------------------------------------
  assign center = !UP_ONLY && |ctrl_r[CTRL_CMS+:2];
  assign down   = (slaveMode == SM_ENCODER) ? !encUp
                : center ? dirDown_r
                : !UP_ONLY && ctrl_r[CTRL_DIR];
  assign atEnd  = down ? (cnt_r == '0) : (cnt_r >= arr_r);
  assign updEvt = tick && atEnd;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r     <= '0;
      dirDown_r <= 1'b0;
    end else if (wrPend_r && wrAddr_r == OFF_CNT) begin
      cnt_r <= hwdata[CNT_W-1:0];
    end else if (trigStart) begin
      cnt_r <= '0;
    end else if (tick) begin
      if (!atEnd) begin
        cnt_r <= down ? cnt_r - 1'b1 : cnt_r + 1'b1;
      end else if (center && slaveMode != SM_ENCODER) begin
        dirDown_r <= !down;
        if (arr_r != '0) begin
          cnt_r <= down ? cnt_r + 1'b1 : cnt_r - 1'b1;
        end
      end else begin
        cnt_r <= down ? arr_r : '0;
      end
    end
  end

  // Control: trigger start sets enable, one-pulse clears it on update
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_r <= CTRL_RST;
    end else begin
      if (wrPend_r && wrAddr_r == OFF_CTRL) begin
        ctrl_r <= hwdata[CTRL_W-1:0];
      end else if (updEvt && ctrl_r[CTRL_OPM]) begin
        ctrl_r[CTRL_EN] <= 1'b0;
      end
      if (trigStart) begin
        ctrl_r[CTRL_EN] <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------
  for (genvar i = 0; i < NUM_CH; i++) begin : gCh
    timer_channel #(.CNT_W(CNT_W)) uChannel (
      .ref_clk (ref_clk),
      .arst_n  (arst_n),
      .modeSel (chCfg_r[CHCFG_W*i+:3]),
      .cnt     (cnt_r),
      .tick    (tick),
      .capIn   (capIn[i]),
      .wrEn    (wrPend_r && wrAddr_r == 8'(OFF_CCR0 + 4 * i)),
      .wrData  (hwdata[CNT_W-1:0]),
      .ccr_r   (ccr[i]),
      .chRef_r (chRef[i]),
      .chEvt_r (chEvt[i])
    );
  end

  // ----------------------------------------------------------------
  // Outputs with dead time on complementary pairs
  // ----------------------------------------------------------------
  for (genvar k = 0; k < NUM_CH; k++) begin : gOut
    logic oe;
    assign oe = chCfg_r[CHCFG_W*k+CHCFG_OE];
    if (k < NUM_COMP) begin : gPair
      logic            refPrev_r;
      logic [DT_W-1:0] dtCnt_r;
      logic            pairEn;
      logic            quiet;
      assign pairEn = ctrl_r[CTRL_CEN+k];
      assign quiet  = (dtCnt_r == '0) && (refPrev_r == chRef[k]);
      always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
          refPrev_r <= 1'b0;
          dtCnt_r   <= '0;
        end else begin
          refPrev_r <= chRef[k];
          if (refPrev_r != chRef[k]) begin
            dtCnt_r <= deadTime_r;
          end else if (dtCnt_r != '0) begin
            dtCnt_r <= dtCnt_r - 1'b1;
          end
        end
      end
      always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
          chOut[k]  <= 1'b0;
          chOutN[k] <= 1'b0;
        end else begin
          chOut[k]  <= oe && chRef[k] && (quiet || !pairEn);
          chOutN[k] <= oe && pairEn && !chRef[k] && quiet;
        end
      end
    end else begin : gSingle
      always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
          chOut[k] <= 1'b0;
        end else begin
          chOut[k] <= oe && chRef[k];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Status, interrupt, DMA and trigger output
  // ----------------------------------------------------------------
  assign setVec = {trigRise, chEvt, updEvt};

  // Hardware set wins over the read-clear
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      status_r <= '0;
    end else begin
      status_r <= (rdStatus ? '0 : status_r) | setVec;
    end
  end

  assign irq = |(status_r & mask_r);

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      dmaReq  <= '0;
      trigOut <= 1'b0;
    end else begin
      dmaReq  <= setVec[NUM_CH:0] & dmaEn_r[NUM_CH:0];
      trigOut <= updEvt;
    end
  end

endmodule : multi_channel_pwm_timer

`default_nettype wire

/* rtl/pwm_timer_pkg.sv */
package pwm_timer_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_PSC    = 8'h04;
  localparam logic [7:0] OFF_ARR    = 8'h08;
  localparam logic [7:0] OFF_CNT    = 8'h0c;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_MASK   = 8'h14;
  localparam logic [7:0] OFF_DMAEN  = 8'h18;
  localparam logic [7:0] OFF_DEAD   = 8'h1c;
  localparam logic [7:0] OFF_CHCFG  = 8'h20;
  localparam logic [7:0] OFF_CCR0   = 8'h24;

  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  localparam int CTRL_W    = 16;
  localparam int CTRL_EN   = 0;
  localparam int CTRL_DIR  = 1;
  localparam int CTRL_CMS  = 2;
  localparam int CTRL_OPM  = 4;
  localparam int CTRL_FRZ  = 5;
  localparam int CTRL_HALL = 6;
  localparam int CTRL_SMS  = 8;
  localparam int CTRL_CEN  = 12;
  localparam int PSC_W     = 16;
  localparam int DT_W      = 8;
  localparam int CHCFG_W   = 4;
  localparam int CHCFG_OE  = 3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [CTRL_W-1:0] CTRL_RST = 16'h0000;
  localparam logic [PSC_W-1:0]  PSC_RST  = 16'h0000;
  localparam logic [DT_W-1:0]   DT_RST   = 8'h00;

  // ----------------------------------------------------------------
  // Modes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SM_INTERNAL, SM_TRIG_START, SM_GATED, SM_EXT_CLOCK, SM_ENCODER
  } slaveMode_t;

  typedef enum logic [2:0] {
    CH_FROZEN, CH_CAP_RISE, CH_CAP_FALL, CH_CAP_BOTH,
    CH_CMP_TOGGLE, CH_PWM, CH_PWM_INV
  } chMode_t;

endpackage : pwm_timer_pkg

/* rtl/timer_channel.sv */
`timescale 1ns/1ps
`default_nettype none

module timer_channel
  import pwm_timer_pkg::*;
#(
  parameter int CNT_W = 32
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             arst_n,
  // Configuration and counter
  input  wire logic [2:0]       modeSel,
  input  wire logic [CNT_W-1:0] cnt,
  input  wire logic             tick,
  // Synchronised capture input
  input  wire logic             capIn,
  // Software write of the compare value
  input  wire logic             wrEn,
  input  wire logic [CNT_W-1:0] wrData,
  // Results
  output logic      [CNT_W-1:0] ccr_r,
  output logic                  chRef_r,
  output logic                  chEvt_r
);

  chMode_t mode;
  logic    capPrev_r;
  logic    capHit;
  logic    cmpHit;

  assign mode   = chMode_t'(modeSel);
  assign cmpHit = tick && (cnt == ccr_r);

  always_comb begin
    unique case (mode)
      CH_CAP_RISE: capHit = capIn & ~capPrev_r;
      CH_CAP_FALL: capHit = ~capIn & capPrev_r;
      CH_CAP_BOTH: capHit = capIn ^ capPrev_r;
      default:     capHit = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      capPrev_r <= 1'b0;
    end else begin
      capPrev_r <= capIn;
    end
  end

  // Capture has priority over a software write
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ccr_r <= '0;
    end else if (capHit) begin
      ccr_r <= cnt;
    end else if (wrEn) begin
      ccr_r <= wrData;
    end
  end

  // Compare of zero keeps PWM low, above reload keeps it high
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      chRef_r <= 1'b0;
    end else begin
      unique case (mode)
        CH_CMP_TOGGLE: if (cmpHit) chRef_r <= ~chRef_r;
        CH_PWM:        chRef_r <= (cnt < ccr_r);
        CH_PWM_INV:    chRef_r <= ~(cnt < ccr_r);
        default:       chRef_r <= 1'b0;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      chEvt_r <= 1'b0;
    end else begin
      chEvt_r <= capHit | (cmpHit && mode != CH_FROZEN);
    end
  end

endmodule : timer_channel

`default_nettype wire

/* tb/enc_hall_model.sv */
`timescale 1ns/1ps
`default_nettype none
module enc_hall_model (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       arst_n,
  // Stepping and sensor levels
  input  wire logic       encStep,
  input  wire logic       encFwd,
  input  wire logic [1:0] auxPin,
  // Pins towards the timer
  output logic      [3:0] capPin
);
  logic [1:0] phase_r;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      phase_r <= 2'h0;
    end else if (encStep) begin
      phase_r <= encFwd ? phase_r + 2'h1 : phase_r - 2'h1;
    end
  end
  // Gray order: one phase line changes per step
  assign capPin = {auxPin, phase_r[1], ^phase_r};
endmodule : enc_hall_model
`default_nettype wire

/* tb/pwm_timer_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module pwm_timer_sva
  import pwm_timer_pkg::*;
#(
  parameter int NUM_CH   = 4,
  parameter int NUM_COMP = 3
) (
  // Clock and reset
  input wire logic                ref_clk,
  input wire logic                arst_n,
  // Bus
  input wire logic                hsel,
  input wire logic [31:0]         haddr,
  input wire logic [1:0]          htrans,
  input wire logic                hwrite,
  input wire logic [2:0]          hsize,
  input wire logic [31:0]         hwdata,
  input wire logic                hready,
  input wire logic [31:0]         hrdata,
  input wire logic                hreadyout,
  input wire logic                hresp,
  // Pins
  input wire logic [NUM_CH-1:0]   capPin,
  input wire logic [NUM_CH-1:0]   chOut,
  input wire logic [NUM_COMP-1:0] chOutN,
  input wire logic                trigIn,
  input wire logic                trigOut,
  input wire logic                dbgHalt,
  input wire logic                irq,
  input wire logic [NUM_CH:0]     dmaReq
);
  // ------
  // Mask shadow
  // ------
  localparam logic [7:0] LAST_OFF = OFF_CCR0 + 8'(4 * NUM_CH - 4);
  logic       wrPend_r;
  logic [7:0] wrAddr_r;
  logic       maskNz_r;
  logic       takeRd;
  assign takeRd = hsel && htrans[1] && hready && !hwrite;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wrPend_r <= 1'b0;
      wrAddr_r <= 8'h00;
      maskNz_r <= 1'b0;
    end else begin
      wrPend_r <= hsel && htrans[1] && hready && hwrite && hsize == 3'h2;
      wrAddr_r <= haddr[7:0];
      if (wrPend_r && wrAddr_r == OFF_MASK) begin
        maskNz_r <= |hwdata[NUM_CH+1:0];
      end
    end
  end
  // ------
  // Properties
  // ------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  sequence seqPulse(sig);
    sig ##1 !sig;
  endsequence
  AST_BUS_OKAY: assert property (hreadyout && !hresp)
    else $error("bus stalled or error response");
  AST_RD_UNMAPPED: assert property (
    takeRd && haddr[7:0] > LAST_OFF |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  AST_IRQ_MASK: assert property (irq |-> maskNz_r)
    else $error("irq with all sources masked");
  AST_TRIG_PULSE: assert property (trigOut |-> seqPulse(trigOut))
    else $error("trigger out not a single pulse");
  AST_DMA_PULSE: assert property (dmaReq[0] |-> seqPulse(dmaReq[0]))
    else $error("update request not a single pulse");
  AST_DMA_UPD: assert property (dmaReq[0] |-> trigOut)
    else $error("update request without update event");
  AST_NO_OVERLAP: assert property (
    (chOut[NUM_COMP-1:0] & chOutN) == '0)
    else $error("both outputs of a pair active");
  AST_DEAD_FALL: assert property ($fell(chOut[0]) |-> !chOutN[0])
    else $error("complement rose with no dead time");
  AST_DEAD_RISE: assert property ($rose(chOutN[0]) |-> !$past(chOut[0]))
    else $error("complement rose right after primary");
endmodule : pwm_timer_sva
bind multi_channel_pwm_timer pwm_timer_sva #(
  .NUM_CH(NUM_CH), .NUM_COMP(NUM_COMP)
) u_sva (
  .ref_clk(ref_clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .capPin(capPin), .chOut(chOut), .chOutN(chOutN),
  .trigIn(trigIn), .trigOut(trigOut), .dbgHalt(dbgHalt), .irq(irq),
  .dmaReq(dmaReq)
);
`default_nettype wire

/* tb/test_multi_channel_pwm_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module test_multi_channel_pwm_timer
  import pwm_timer_pkg::*;
;
  logic        ref_clk = 1'b0;
  logic        arst_n, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans, auxPin;
  logic [2:0]  hsize, chOutN;
  logic [3:0]  capPin, chOut;
  logic        trigIn, trigOut, dbgHalt, irq, encStep, encFwd, dmaSeen;
  logic [4:0]  dmaReq;
  int          errors, checks, cycles;
  assign hready = hreadyout;
  always #4 ref_clk = ~ref_clk;
  multi_channel_pwm_timer u_dut (
    .ref_clk(ref_clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .capPin(capPin), .chOut(chOut), .chOutN(chOutN),
    .trigIn(trigIn), .trigOut(trigOut), .dbgHalt(dbgHalt), .irq(irq),
    .dmaReq(dmaReq));
  enc_hall_model u_enc (.ref_clk(ref_clk), .arst_n(arst_n),
    .encStep(encStep), .encFwd(encFwd), .auxPin(auxPin), .capPin(capPin));
  // ------
  // Helpers
  // ------
  task automatic chk(input string what, input logic [31:0] got, exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic end_of_test;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_of_test
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      end_of_test();
    end
  end
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr  <= {24'h0, a};
    hsize  <= 3'h2;
    do @(posedge ref_clk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge ref_clk); while (hready !== 1'b1);
    q = hrdata;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    xfer(1'b0, a, 32'h0, q);
  endtask : rd
  task automatic step2(output logic [31:0] dl);
    logic [31:0] a, b;
    repeat (3) @(posedge ref_clk);
    rd(OFF_CNT, a);
    rd(OFF_CNT, b);
    dl = b - a;
  endtask : step2
  task automatic rstDut(input int n);
    arst_n <= 1'b0;
    repeat (n) @(posedge ref_clk);
    arst_n <= 1'b1;
    @(posedge ref_clk);
  endtask : rstDut
  task automatic waitUpd(output int n);
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (trigOut !== 1'b1 && n < 200);
    dmaSeen = dmaReq[0];
  endtask : waitUpd
  task automatic cnt10(output int h, hn);
    h = 0;
    hn = 0;
    repeat (20) @(posedge ref_clk);
    repeat (10) begin
      @(posedge ref_clk);
      h += int'(chOut[0]);
      hn += int'(chOutN[0]);
    end
  endtask : cnt10
  // ------
  // Scenarios
  // ------
  task automatic t_regs;
    logic [31:0] q;
    rd(OFF_CTRL, q);
    chk("ctrl reset", q, 32'h0);
    rd(OFF_ARR, q);
    chk("reload reset", q, 32'hffffffff);
    wr(OFF_PSC, 32'hffff1234);
    rd(OFF_PSC, q);
    chk("prescaler width", q, 32'h00001234);
    wr(8'h40, 32'h5a);
    rd(8'h40, q);
    chk("unmapped", q, 32'h0);
    $display("t_regs done");
  endtask : t_regs
  task automatic t_update;
    logic [31:0] q;
    int n;
    rstDut(2);
    wr(OFF_PSC, 32'h1);
    wr(OFF_ARR, 32'h4);
    wr(OFF_MASK, 32'h1);
    wr(OFF_DMAEN, 32'h1);
    wr(OFF_CTRL, 32'h1);
    waitUpd(n);
    waitUpd(n);
    chk("update period", 32'(n), 32'd10);
    chk("update dma", {31'h0, dmaSeen}, 32'h1);
    chk("irq set", {31'h0, irq}, 32'h1);
    wr(OFF_CTRL, 32'h0);
    rd(OFF_STATUS, q);
    chk("update flag", {31'h0, q[0]}, 32'h1);
    rd(OFF_STATUS, q);
    chk("flag cleared", {31'h0, q[0]}, 32'h0);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    rstDut(2);
    wr(OFF_ARR, 32'h4);
    wr(OFF_CTRL, 32'h5);
    waitUpd(n);
    waitUpd(n);
    chk("center period", 32'(n), 32'd4);
    wr(OFF_CTRL, 32'h11);
    repeat (12) @(posedge ref_clk);
    rd(OFF_CTRL, q);
    chk("one pulse stop", q, 32'h10);
    $display("t_update done");
  endtask : t_update
  task automatic t_count;
    logic [31:0] dl;
    rstDut(2);
    wr(OFF_CTRL, 32'h3);
    step2(dl);
    chk("down count", dl, 32'hfffffffe);
    wr(OFF_CTRL, 32'h21);
    dbgHalt <= 1'b1;
    step2(dl);
    chk("frozen", dl, 32'h0);
    dbgHalt <= 1'b0;
    step2(dl);
    chk("running", dl, 32'h2);
    wr(OFF_CTRL, 32'h201);
    step2(dl);
    chk("gate closed", dl, 32'h0);
    trigIn <= 1'b1;
    step2(dl);
    chk("gate open", dl, 32'h2);
    rd(OFF_STATUS, dl);
    chk("trigger flag", {31'h0, dl[5]}, 32'h1);
    trigIn <= 1'b0;
    wr(OFF_CTRL, 32'h100);
    trigIn <= 1'b1;
    step2(dl);
    chk("trigger start", dl, 32'h2);
    wr(OFF_CTRL, 32'h301);
    step2(dl);
    chk("ext clock idle", dl, 32'h0);
    $display("t_count done");
  endtask : t_count
  task automatic t_pwm;
    int md[4] = '{13, 13, 13, 14};
    int cc[4] = '{3, 0, 10, 3};
    int ex[4] = '{3, 0, 10, 7};
    int h, hn;
    rstDut(2);
    wr(OFF_ARR, 32'h9);
    wr(OFF_CTRL, 32'h1);
    for (int i = 0; i < 4; i++) begin
      wr(OFF_CHCFG, 32'(md[i]));
      wr(OFF_CCR0, 32'(cc[i]));
      cnt10(h, hn);
      chk("pwm duty", 32'(h), 32'(ex[i]));
    end
    wr(OFF_DEAD, 32'h1);
    wr(OFF_CCR0, 32'h5);
    wr(OFF_CHCFG, 32'hd);
    wr(OFF_CTRL, 32'h1001);
    cnt10(h, hn);
    chk("dead primary", 32'(h), 32'd3);
    chk("dead complement", 32'(hn), 32'd3);
    wr(OFF_DMAEN, 32'h2);
    h = 0;
    repeat (10) begin
      @(posedge ref_clk);
      h += int'(dmaReq[1]);
    end
    chk("channel dma", 32'(h), 32'd1);
    $display("t_pwm done");
  endtask : t_pwm
  task automatic t_sensors;
    logic [31:0] q;
    rstDut(2);
    wr(OFF_ARR, 32'd1000);
    wr(OFF_CTRL, 32'h401);
    wr(OFF_CNT, 32'd100);
    for (int i = 0; i < 8; i++) begin
      encFwd <= i < 4;
      encStep <= 1'b1;
      @(posedge ref_clk);
      encStep <= 1'b0;
      repeat (5) @(posedge ref_clk);
      if (i == 3) rd(OFF_CNT, q);
      if (i == 3) chk("enc fwd", q, 32'd104);
    end
    rd(OFF_CNT, q);
    chk("enc back", q, 32'd100);
    rstDut(2);
    wr(OFF_CHCFG, 32'h1003);
    wr(OFF_CTRL, 32'h41);
    auxPin <= 2'b11;
    repeat (6) @(posedge ref_clk);
    rd(OFF_STATUS, q);
    chk("capture flags", q & 32'h12, 32'h12);
    chk("masked irq", {31'h0, irq}, 32'h0);
    auxPin <= 2'b00;
    $display("t_sensors done");
  endtask : t_sensors
  initial begin
    {arst_n, hsel, hwrite, trigIn, dbgHalt, encStep, encFwd} = '0;
    {haddr, hwdata, htrans, hsize, auxPin} = '0;
    rstDut(20);
    t_regs();
    t_update();
    t_count();
    t_pwm();
    t_sensors();
    end_of_test();
  end
endmodule : test_multi_channel_pwm_timer
`default_nettype wire
